// *** rtl/phy_mgmt_device.sv ***
// management serial slave of the transceiver with its mode and interrupt registers
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`include "mgmt_consts.svh"
module phy_mgmt_device
  import mgmt_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  mgmt_link_if.device      link,
  input  wire logic [2:0]  station_address_strap,
  input  wire logic        broadcast_disable_strap,
  input  wire logic [7:0]  interrupt_events,
  input  wire logic        partner_crossed,
  input  wire logic [15:0] cable_diag_status,
  output logic             interrupt_request_out,
  output logic             crossover_mdix,
  output logic             auto_crossover_on,
  output logic             speed_100,
  output logic             full_duplex,
  output logic             autoneg_enable,
  output logic             local_loopback,
  output logic             remote_loopback,
  output logic             cable_diag_start
);

  dev_state_s r;
  dev_state_s n;

  logic        mdc_rise;
  logic        mdc_fall;
  logic        line_bit;
  logic [11:0] full_header;
  logic [15:0] write_word;
  logic [15:0] read_word;
  logic        bcast_enabled;
  logic        address_ok;
  logic        pending;

  //////////////////////////////////////////////////////////////////////////////
  // edge detection on the synchronised link signals

  assign mdc_rise    = r.sync_mdc[1] && !r.sync_mdc[2];
  assign mdc_fall    = !r.sync_mdc[1] && r.sync_mdc[2];
  assign line_bit    = r.sync_mdio[1];
  assign full_header = {r.header[10:0], line_bit};
  assign write_word  = {r.shift[14:0], line_bit};

  assign bcast_enabled = !r.bcast_strap_off
                      && !r.misc_override_control[`MISC_BCAST_OFF_BIT];
  assign address_ok = (full_header[9:8] == 2'b00)
                   && ((full_header[7:5] == r.own_address)
                    || (full_header[7:5] == 3'd0 && bcast_enabled));

  //////////////////////////////////////////////////////////////////////////////
  // register read mux

  always_comb begin
    read_word = 16'h0000;
    case (full_header[4:0])
      `REG_BASIC_CONTROL:      read_word = r.basic_control;
      `REG_MISC_OVERRIDE:      read_word = r.misc_override_control;
      `REG_INTERRUPT:          read_word = {r.int_enable, r.int_status};
      `REG_CABLE_DIAG:         read_word = cable_diag_status;
      `REG_PHY_CONTROL_SECOND: read_word = r.phy_control_second;
      default:                 read_word = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = r;
    n.sync_mdc   = {r.sync_mdc[1:0], link.mdc};
    n.sync_mdio  = {r.sync_mdio[0], link.mdio};
    n.sync_strap = {r.sync_strap[3:0], broadcast_disable_strap, station_address_strap};
    n.diag_start = 1'b0;

    // straps caught once the synchroniser has filled after reset
    if (r.strap_wait != 2'd3) begin
      n.strap_wait = r.strap_wait + 2'd1;
    end
    if (r.strap_wait == 2'd2) begin
      n.own_address     = r.sync_strap[6:4];
      n.bcast_strap_off = r.sync_strap[7];
    end

    n.int_status = r.int_status | interrupt_events;

    if (mdc_rise) begin
      case (r.phase)
        st_preamble: begin
          if (line_bit) begin
            n.count = (r.count == `PREAMBLE_ONES) ? r.count : r.count + 6'd1;
          end else if (r.count == `PREAMBLE_ONES) begin
            n.phase = st_start;
          end else begin
            n.count = 6'd0;
          end
        end
        st_start: begin
          n.count = 6'd0;
          n.phase = line_bit ? st_header : st_preamble;
        end
        st_header: begin
          n.header = full_header;
          n.count  = r.count + 6'd1;
          if (r.count == 6'd11) begin
            n.count = 6'd0;
            if (address_ok && (full_header[11:10] == `OP_READ)) begin
              n.phase   = st_turnaround;
              n.is_read = 1'b1;
              n.shift   = read_word;
              if (full_header[4:0] == `REG_INTERRUPT) begin
                n.int_status = interrupt_events;
              end
            end else if (address_ok && (full_header[11:10] == `OP_WRITE)) begin
              n.phase   = st_turnaround;
              n.is_read = 1'b0;
            end else begin
              n.phase = st_preamble;
            end
          end
        end
        st_turnaround: begin
          n.count = r.count + 6'd1;
          if (r.count == 6'd1) begin
            n.count = 6'd0;
            n.phase = st_data;
          end
        end
        st_data: begin
          n.count = r.count + 6'd1;
          if (!r.is_read) begin
            n.shift = write_word;
          end
          if (r.count == 6'd15) begin
            n.count = 6'd0;
            n.phase = st_preamble;
            if (!r.is_read) begin
              case (r.header[4:0])
                `REG_BASIC_CONTROL:      n.basic_control = write_word;
                `REG_MISC_OVERRIDE:      n.misc_override_control = write_word;
                `REG_INTERRUPT:          n.int_enable = write_word[15:8];
                `REG_CABLE_DIAG:         n.diag_start = write_word[`DIAG_START_BIT];
                `REG_PHY_CONTROL_SECOND: n.phy_control_second = write_word;
                default: ;
              endcase
            end
          end
        end
        default: begin
          n.phase = st_preamble;
          n.count = 6'd0;
        end
      endcase
    end

    // drive after the falling edge so data is stable by the next rise
    if (mdc_fall) begin
      n.mdio_oe_n = 1'b1;
      n.mdio_out  = 1'b1;
      if (r.is_read && r.phase == st_turnaround && r.count == 6'd1) begin
        n.mdio_oe_n = 1'b0;
        n.mdio_out  = 1'b0;
      end else if (r.is_read && r.phase == st_data) begin
        n.mdio_oe_n = 1'b0;
        n.mdio_out  = r.shift[15];
        n.shift     = {r.shift[14:0], 1'b0};
      end
    end

    pending   = |(r.int_status & r.int_enable);
    n.irq_pin = r.phy_control_second[`PC2_INT_ACTIVE_HI_BIT] ? pending : !pending;

    if (!r.phy_control_second[`PC2_AUTO_MDIX_OFF_BIT]) begin
      n.mdix = partner_crossed;
    end else begin
      n.mdix = r.phy_control_second[`PC2_MDIX_SELECT_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r                       <= '0;
      r.phase                 <= st_preamble;
      r.basic_control         <= `BASIC_CONTROL_RESET;
      r.misc_override_control <= `MISC_OVERRIDE_RESET;
      r.phy_control_second    <= `PHY_CONTROL_RESET;
      r.mdio_out              <= 1'b1;
      r.mdio_oe_n             <= 1'b1;
      r.irq_pin               <= 1'b1;
    end else begin
      r <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.dev_out          = r.mdio_out;
  assign link.dev_oe_n         = r.mdio_oe_n;
  assign interrupt_request_out = r.irq_pin;
  assign crossover_mdix        = r.mdix;
  assign auto_crossover_on     = !r.phy_control_second[`PC2_AUTO_MDIX_OFF_BIT];
  assign speed_100             = r.basic_control[`BC_SPEED_100_BIT];
  assign full_duplex           = r.basic_control[`BC_FULL_DUPLEX_BIT];
  assign autoneg_enable        = r.basic_control[`BC_AUTONEG_BIT];
  assign local_loopback        = r.basic_control[`BC_LOOPBACK_BIT]
                              && r.basic_control[`BC_FULL_DUPLEX_BIT];
  assign remote_loopback       = r.phy_control_second[`PC2_REMOTE_LOOP_BIT];
  assign cable_diag_start      = r.diag_start;

endmodule

// *** rtl/mgmt_consts.svh ***
// offsets, field positions, reset values and timing counts of the management link
`ifndef MGMT_CONSTS_SVH
`define MGMT_CONSTS_SVH

// device register addresses
`define REG_BASIC_CONTROL      5'h00
`define REG_MISC_OVERRIDE      5'h16
`define REG_INTERRUPT          5'h1b
`define REG_CABLE_DIAG         5'h1d
`define REG_PHY_CONTROL_SECOND 5'h1f

// device field positions
`define BC_LOOPBACK_BIT        14
`define BC_SPEED_100_BIT       13
`define BC_AUTONEG_BIT         12
`define BC_FULL_DUPLEX_BIT     8
`define MISC_BCAST_OFF_BIT     9
`define PC2_MDIX_SELECT_BIT    14
`define PC2_AUTO_MDIX_OFF_BIT  13
`define PC2_INT_ACTIVE_HI_BIT  9
`define PC2_REMOTE_LOOP_BIT    2
`define DIAG_START_BIT         15

// device reset values
`define BASIC_CONTROL_RESET    16'h3100
`define MISC_OVERRIDE_RESET    16'h0000
`define PHY_CONTROL_RESET      16'h0000

// frame layout
`define PREAMBLE_ONES          6'd32
`define OP_READ                2'b10
`define OP_WRITE               2'b01
`define FRAME_BITS             7'd64
`define FRAME_TA_FIRST         7'd46
`define FRAME_TA_SECOND        7'd47
`define FRAME_DATA_FIRST       7'd48

// host own register offsets
`define HOST_REG_COMMAND       2'h0
`define HOST_REG_WRITE_DATA    2'h1
`define HOST_REG_STATUS        2'h2
`define HOST_REG_READ_DATA     2'h3
`define CMD_WRITE_BIT          10

// timing
`define CLK_PERIOD_NS          10
`define MDC_PERIOD_NS          160
`define MDC_HALF_CYCLES        ((`MDC_PERIOD_NS / 2) / `CLK_PERIOD_NS)

`endif

// *** rtl/mgmt_pkg.sv ***
// types shared by both ends of the management link
package mgmt_pkg;

  typedef enum logic [2:0] {
    st_preamble,
    st_start,
    st_header,
    st_turnaround,
    st_data
  } dev_phase_e;

  typedef struct packed {
    logic [2:0]  sync_mdc;
    logic [1:0]  sync_mdio;
    logic [7:0]  sync_strap;
    logic [1:0]  strap_wait;
    logic [2:0]  own_address;
    logic        bcast_strap_off;
    dev_phase_e  phase;
    logic [5:0]  count;
    logic [11:0] header;
    logic [15:0] shift;
    logic        is_read;
    logic [15:0] basic_control;
    logic [15:0] misc_override_control;
    logic [7:0]  int_enable;
    logic [7:0]  int_status;
    logic [15:0] phy_control_second;
    logic        mdio_out;
    logic        mdio_oe_n;
    logic        irq_pin;
    logic        mdix;
    logic        diag_start;
  } dev_state_s;

  typedef struct packed {
    logic [1:0]  sync_mdio;
    logic        busy;
    logic        ack_seen;
    logic        is_write;
    logic [4:0]  phy_address;
    logic [4:0]  reg_address;
    logic [15:0] write_data;
    logic [15:0] read_data;
    logic [63:0] frame;
    logic [6:0]  bit_index;
    logic [7:0]  phase;
    logic        mdc;
    logic        mdio_out;
    logic        mdio_oe_n;
    logic [15:0] bus_rdata;
  } host_state_s;

endpackage

// *** rtl/mgmt_link_if.sv ***
// management serial link: clock from the host, one shared data line
`timescale 1ns/1ns
interface mgmt_link_if;
  logic mdc;
  logic host_out;
  logic host_oe_n;
  logic dev_out;
  logic dev_oe_n;
  logic mdio;

  // resolved line level; an undriven line is pulled high
  assign mdio = !host_oe_n ? host_out : (!dev_oe_n ? dev_out : 1'b1);

  modport host (output mdc, output host_out, output host_oe_n, input mdio);
  modport device (input mdc, input mdio, output dev_out, output dev_oe_n);
endinterface

// *** rtl/mgmt_host.sv ***
// management link master with a small command register port
`timescale 1ns/1ns
`include "mgmt_consts.svh"
module mgmt_host
  import mgmt_pkg::*;
#(
  parameter int HALF_CYCLES = `MDC_HALF_CYCLES
) (
  input  wire logic   ref_clk,
  input  wire logic   nrst,
  mgmt_link_if.host   link,
  input  wire logic [1:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [15:0] bus_rdata,
  output logic             busy
);

  host_state_s r;
  host_state_s n;

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);
  localparam logic [7:0] FULL_LAST = 8'(2 * HALF_CYCLES - 1);

  always_comb begin
    n = r;
    n.sync_mdio = {r.sync_mdio[0], link.mdio};
    if (bus_wr) begin
      case (bus_addr)
        `HOST_REG_COMMAND: begin
          if (!r.busy) begin
            n.busy        = 1'b1;
            n.ack_seen    = 1'b0;
            n.is_write    = bus_wdata[`CMD_WRITE_BIT];
            n.phy_address = bus_wdata[9:5];
            n.reg_address = bus_wdata[4:0];
            n.bit_index   = 7'd0;
            n.phase       = 8'd0;
            n.mdc         = 1'b0;
            // preamble, start, opcode, addresses, turnaround, data
            n.frame = {32'hffff_ffff, 2'b01,
                       bus_wdata[`CMD_WRITE_BIT] ? `OP_WRITE : `OP_READ,
                       bus_wdata[9:5], bus_wdata[4:0], 2'b10, r.write_data};
            n.mdio_out  = 1'b1;
            n.mdio_oe_n = 1'b0;
          end
        end
        `HOST_REG_WRITE_DATA: n.write_data = bus_wdata;
        default: ;
      endcase
    end
    if (bus_rd) begin
      case (bus_addr)
        `HOST_REG_STATUS:    n.bus_rdata = {14'h0000, r.ack_seen, r.busy};
        `HOST_REG_READ_DATA: n.bus_rdata = r.read_data;
        `HOST_REG_WRITE_DATA: n.bus_rdata = r.write_data;
        default:             n.bus_rdata = 16'h0000;
      endcase
    end
    if (r.busy) begin
      n.phase = r.phase + 8'd1;
      if (r.phase == HALF_LAST) begin
        n.mdc = 1'b1;
      end
      if (r.phase == FULL_LAST) begin
        n.phase = 8'd0;
        n.mdc   = 1'b0;
        // sample late in the high phase, after the device has settled
        if (!r.is_write && r.bit_index == `FRAME_TA_SECOND) begin
          n.ack_seen = !r.sync_mdio[1];
        end
        if (!r.is_write && r.bit_index >= `FRAME_DATA_FIRST) begin
          n.read_data = {r.read_data[14:0], r.sync_mdio[1]};
        end
        n.frame     = {r.frame[62:0], 1'b0};
        n.bit_index = r.bit_index + 7'd1;
        n.mdio_out  = r.frame[62];
        // release the line for a read turnaround and data
        n.mdio_oe_n = !r.is_write && (r.bit_index + 7'd1 >= `FRAME_TA_FIRST);
        if (r.bit_index == `FRAME_BITS - 7'd1) begin
          n.busy      = 1'b0;
          n.ack_seen  = r.is_write ? 1'b1 : n.ack_seen;
          n.mdio_oe_n = 1'b1; // idle released
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      r           <= '0;
      r.mdio_out  <= 1'b1;
      r.mdio_oe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.mdc       = r.mdc;
  assign link.host_out  = r.mdio_out;
  assign link.host_oe_n = r.mdio_oe_n;
  assign bus_rdata      = r.bus_rdata;
  assign busy           = r.busy;

endmodule

// *** tb/phy_mgmt_link_asserts.sv ***
// concurrent checks on the management link between host and device
`timescale 1ns/1ns
module phy_mgmt_link_asserts (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic host_out,
  input wire logic host_oe_n,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  input wire logic mdio
);
  logic [10:0] dev_cnt;
  logic [10:0] host_cnt;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // length of the current drive stretch of each end, in clocks
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      dev_cnt  <= 11'h000;
      host_cnt <= 11'h000;
    end else begin
      dev_cnt  <= dev_oe_n ? 11'h000 : dev_cnt + 11'h001;
      host_cnt <= host_oe_n ? 11'h000 : host_cnt + 11'h001;
    end
  end

  ////////////////////////////////////////////////////////////
  sequence mdc_high_phase;
    mdc [*8] ##1 !mdc;
  endsequence

  sequence dev_first_bit;
    !dev_out && !mdio;
  endsequence

  a_one_driver: assert property (!(!host_oe_n && !dev_oe_n))
    else $error("host and device drive the line together");
  a_mdc_high_len: assert property ($rose(mdc) |-> mdc_high_phase)
    else $error("mdc high phase is not eight clocks");
  a_host_stable_high: assert property (mdc && $past(mdc) && !host_oe_n |-> $stable(host_out))
    else $error("host data moved while mdc high");
  a_dev_stable_high: assert property (
    mdc && $past(mdc) |-> $stable(dev_oe_n) && (dev_oe_n || $stable(dev_out)))
    else $error("device data moved while mdc high");
  a_turnaround_zero: assert property ($fell(dev_oe_n) |-> dev_first_bit)
    else $error("device turnaround bit is not zero");
  a_dev_after_release: assert property ($fell(dev_oe_n) |-> $past(host_oe_n, 16))
    else $error("device drove before host released");
  a_dev_drive_len: assert property ($rose(dev_oe_n) |-> dev_cnt == 11'h110)
    else $error("device drive is not seventeen bits");
  a_host_drive_len: assert property ($rose(host_oe_n) |->
    host_cnt inside {[11'h2d8:11'h2e8], [11'h3f8:11'h408]})
    else $error("host drive length wrong");
endmodule

// *** tb/phy_mgmt_serial_and_mode_ctrl_bench.sv ***
// self-checking bench: host and device joined over the management link
`timescale 1ns/1ns
module phy_mgmt_serial_and_mode_ctrl_bench;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  strap = 3'h5;
  logic        bc_off = 1'b0;
  logic [7:0]  events = 8'h00;
  logic        crossed = 1'b0;
  logic [15:0] diag = 16'h8a5c;
  logic [1:0]  bus_addr = 2'h0;
  logic [15:0] bus_wdata = 16'h0000;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [15:0] bus_rdata;
  logic        busy, irq, mdix, auto_x, spd, fdx, aneg, lloop, rloop, dstart;
  logic [63:0] cap = 64'h0;
  logic        mdc_q = 1'b0;
  int          n_start = 0;
  int          n_mismatch = 0;
  int          n_tests = 0;

  always #5 ref_clk = ~ref_clk;

  mgmt_link_if link ();
  mgmt_host mgmt_host_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .busy(busy));
  phy_mgmt_device phy_mgmt_device_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link),
    .station_address_strap(strap), .broadcast_disable_strap(bc_off), .interrupt_events(events),
    .partner_crossed(crossed), .cable_diag_status(diag), .interrupt_request_out(irq),
    .crossover_mdix(mdix), .auto_crossover_on(auto_x), .speed_100(spd), .full_duplex(fdx),
    .autoneg_enable(aneg), .local_loopback(lloop), .remote_loopback(rloop),
    .cable_diag_start(dstart));
  phy_mgmt_link_asserts phy_mgmt_link_asserts_inst (.ref_clk(ref_clk), .nrst(nrst),
    .mdc(link.mdc), .host_out(link.host_out), .host_oe_n(link.host_oe_n),
    .dev_out(link.dev_out), .dev_oe_n(link.dev_oe_n), .mdio(link.mdio));

  // line bits as seen on each mdc rise, and start pulses
  always @(posedge ref_clk) begin
    mdc_q <= link.mdc;
    if (link.mdc && !mdc_q) cap <= {cap[62:0], link.mdio};
    if (dstart === 1'b1) n_start <= n_start + 1;
  end

  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_write(input logic [1:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
  endtask

  task automatic bus_read(input logic [1:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    @(negedge ref_clk);
    d = bus_rdata;
  endtask

  task automatic frame(input logic w, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] d);
    int k;
    k = 0;
    bus_write(2'h1, d);
    bus_write(2'h0, {5'h00, w, pa, ra});
    repeat (3) @(posedge ref_clk);
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    // a frame that never finishes counts against the run
    if (k >= 2000) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, 16'h0001, 16'h0000);
    end
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    frame(1'b1, pa, ra, d);
  endtask

  task automatic rd_chk(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] v;
    frame(1'b0, pa, ra, 16'h0000);
    bus_read(2'h3, v);
    chk(v, e);
  endtask

  task automatic pulse(input logic [7:0] e);
    @(posedge ref_clk);
    events <= e;
    @(posedge ref_clk);
    events <= 8'h00;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic restart();
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] v;
    logic [63:0] fr;
    fr = {32'hffff_ffff, 2'b01, 2'b01, 5'h05, 5'h1f, 2'b10, 16'h6000};
    restart();
    chk({irq, auto_x, spd, aneg, fdx, lloop, rloop, mdix}, 16'h00f8);
    rd_chk(5'h05, 5'h00, 16'h3100);
    rd_chk(5'h05, 5'h1f, 16'h0000);
    bus_read(2'h2, v);
    chk(v, 16'h0002);
    wr(5'h05, 5'h1f, 16'h6000);
    for (int i = 0; i < 4; i++) chk(cap[i*16 +: 16], fr[i*16 +: 16]);
    chk({auto_x, mdix}, 16'h0001);
    wr(5'h05, 5'h1f, 16'h2000);
    chk({auto_x, mdix}, 16'h0000);
    wr(5'h06, 5'h1f, 16'h6000);
    chk({auto_x, mdix}, 16'h0000);
    rd_chk(5'h06, 5'h00, 16'hffff);
    bus_read(2'h2, v);
    chk(v, 16'h0000);
    wr(5'h05, 5'h00, 16'h2100);
    wr(5'h00, 5'h1f, 16'h0004);
    chk({auto_x, rloop}, 16'h0003);
    rd_chk(5'h00, 5'h1f, 16'h0004);
    @(posedge ref_clk);
    crossed <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({15'h0000, mdix}, 16'h0001);
    crossed <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({15'h0000, mdix}, 16'h0000);
    wr(5'h05, 5'h16, 16'h0200);
    wr(5'h00, 5'h1f, 16'h0000);
    chk({15'h0000, rloop}, 16'h0001);
    wr(5'h05, 5'h00, 16'h4100);
    chk({lloop, spd, aneg, fdx}, 16'h0009);
    wr(5'h05, 5'h00, 16'h4000);
    chk({lloop, fdx}, 16'h0000);
    wr(5'h05, 5'h1b, 16'h0100);
    pulse(8'h02);
    chk({15'h0000, irq}, 16'h0001);
    rd_chk(5'h05, 5'h1b, 16'h0102);
    rd_chk(5'h05, 5'h1b, 16'h0100);
    pulse(8'h01);
    chk({15'h0000, irq}, 16'h0000);
    wr(5'h05, 5'h1f, 16'h0200);
    chk({15'h0000, irq}, 16'h0001);
    rd_chk(5'h05, 5'h1b, 16'h0101);
    chk({15'h0000, irq}, 16'h0000);
    rd_chk(5'h05, 5'h1d, 16'h8a5c);
    wr(5'h05, 5'h1d, 16'h8000);
    chk(n_start[15:0], 16'h0001);
    strap  <= 3'h3;
    bc_off <= 1'b1;
    restart();
    wr(5'h00, 5'h1f, 16'h0004);
    chk({15'h0000, rloop}, 16'h0000);
    rd_chk(5'h03, 5'h00, 16'h3100);
    print_verdict();
  end

  // about twenty frames of a thousand clocks each fit well inside this span
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
